/* dcc_consts.svh */
// Constants for the DDR3 command and control pin block.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
`define DCC_NUM_RANKS 4
`define DCC_ODT_CYCLES 6
`define DCC_RX_TERM_CYCLES 8
`define DCC_CODE_NOP 3'h7
`define DCC_CODE_ACT 3'h3
`define DCC_CODE_READ 3'h5
`define DCC_CODE_WRITE 3'h4
`define DCC_CODE_PRE 3'h2
`define DCC_CODE_REF 3'h1
`define DCC_CODE_MRS 3'h0
`define DCC_CS_NONE 4'hF
`endif

/* dcc_pkg.sv */
// Types and the command decode function of the DDR3 command and control pin block.
`include "dcc_consts.svh"
package dcc_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS}
    dcc_cmd_t;
  typedef enum logic [1:0] {OP_PD_ENTER, OP_PD_EXIT, OP_SR_ENTER, OP_SR_EXIT} dcc_pwr_op_t;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF} dcc_pwr_state_t;

  // Returns {row strobe, column strobe, write strobe}, all active low.
  function automatic logic [2:0] dcc_cmd_code(input dcc_cmd_t cmd);
    case (cmd)
      CMD_ACT: dcc_cmd_code = `DCC_CODE_ACT;
      CMD_READ: dcc_cmd_code = `DCC_CODE_READ;
      CMD_WRITE: dcc_cmd_code = `DCC_CODE_WRITE;
      CMD_PRE: dcc_cmd_code = `DCC_CODE_PRE;
      CMD_REF: dcc_cmd_code = `DCC_CODE_REF;
      CMD_MRS: dcc_cmd_code = `DCC_CODE_MRS;
      default: dcc_cmd_code = `DCC_CODE_NOP;
    endcase
  endfunction : dcc_cmd_code
endpackage : dcc_pkg

/* dcc_cmd_encode.sv */
// Command encoder: turns a command word into chip select and strobe levels.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_cmd_encode
  import dcc_pkg::*;
(
  // Command word
  input wire logic sel,
  input wire dcc_cmd_t cmd,
  input wire logic [1:0] rank,
  // Encoded levels
  output logic [3:0] cs_n,
  output logic [2:0] strobes_n
);
  always_comb
  begin
    cs_n = `DCC_CS_NONE;
    strobes_n = `DCC_CODE_NOP;
    if (sel)
    begin
      cs_n = ~(4'h1 << rank); // see [RULE9]
      strobes_n = dcc_cmd_code(cmd); // see [RULE19]
    end
  end
endmodule : dcc_cmd_encode
`default_nettype wire

/* dcc_link_stage.sv */
// Memory clock side: takes command words across and drives the pins.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_link_stage
  import dcc_pkg::*;
#(
  parameter int ODT_CYCLES = `DCC_ODT_CYCLES
)
(
  // Memory clock and the controller reset
  input wire logic mem_clk,
  input wire logic nrst,
  // Word from the controller clock, stable while the toggle is unanswered
  input wire logic req_tgl,
  input wire logic [3:0] w_cs_n,
  input wire logic [2:0] w_strobes_n,
  input wire logic [3:0] w_cke,
  input wire logic w_write,
  input wire logic w_odt,
  input wire logic [1:0] w_rank,
  output logic ack_tgl,
  // Pins
  output logic [3:0] cke_r,
  output logic [3:0] cs_n_r,
  output logic [3:0] odt_r,
  output logic [2:0] strobes_n_r
);
  logic rst_meta_r, rst_sync_r, tgl_meta_r, tgl_sync_r, tgl_seen_r, new_word;
  logic [7:0] odt_cnt_r [4];

  always_ff @(posedge mem_clk)
  begin
    rst_meta_r <= nrst;
    rst_sync_r <= rst_meta_r;
    tgl_meta_r <= req_tgl;
    tgl_sync_r <= tgl_meta_r;
  end

  assign new_word = tgl_sync_r ^ tgl_seen_r;

  // Pins change only on memory clock edges, so entry and exit are edge aligned.
  always_ff @(posedge mem_clk)
  begin
    if (!rst_sync_r)
    begin
      tgl_seen_r <= 1'b0;
      ack_tgl <= 1'b0;
      cke_r <= 4'h0;
      cs_n_r <= `DCC_CS_NONE;
      strobes_n_r <= `DCC_CODE_NOP;
    end
    else if (new_word)
    begin
      tgl_seen_r <= tgl_sync_r;
      ack_tgl <= tgl_sync_r;
      cke_r <= w_cke; // see [RULE3]
      cs_n_r <= w_cs_n; // see [RULE10]
      strobes_n_r <= w_strobes_n; // see [RULE17] see [RULE18]
    end
    else
    begin
      cs_n_r <= `DCC_CS_NONE;
      strobes_n_r <= `DCC_CODE_NOP;
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_odt
    logic load;
    assign load = new_word && w_write && w_odt && (w_rank == 2'(i));
    always_ff @(posedge mem_clk)
    begin
      if (!rst_sync_r)
      begin
        odt_cnt_r[i] <= 8'h00;
        odt_r[i] <= 1'b0;
      end
      else if (load)
      begin
        odt_cnt_r[i] <= 8'(ODT_CYCLES - 1); // see [RULE11] see [RULE15]
        odt_r[i] <= 1'b1;
      end
      else if (odt_cnt_r[i] != 8'h00)
      begin
        odt_cnt_r[i] <= odt_cnt_r[i] - 8'h01;
        odt_r[i] <= 1'b1;
      end
      else
        odt_r[i] <= 1'b0;
    end

    // Checked per rank, since the word may move on before the window ends.
    a_write_odt: assert property (@(posedge mem_clk) disable iff (!rst_sync_r) // see [RULE11]
      load |=> odt_r[i] [*6]) else $error("odt window short");
  end

  a_one_rank: assert property (@(posedge mem_clk) disable iff (!rst_sync_r) // see [RULE9]
    $countones(~cs_n_r) <= 1) else $error("more than one rank selected");
  a_idle_deselect: assert property (@(posedge mem_clk) disable iff (!rst_sync_r) // see [RULE10]
    !new_word |=> cs_n_r == 4'hF && strobes_n_r == 3'h7) else $error("idle cycle not deselect");
  a_code_passed: assert property (@(posedge mem_clk) disable iff (!rst_sync_r) // see [RULE19]
    new_word |=> strobes_n_r == $past(w_strobes_n) && cs_n_r == $past(w_cs_n))
    else $error("command code not driven");
  a_cke_word: assert property (@(posedge mem_clk) disable iff (!rst_sync_r) // see [RULE16]
    new_word |=> cke_r == $past(w_cke)) else $error("clock enable not taken");
  c_write_odt: cover property (@(posedge mem_clk) new_word && w_write && w_odt);
endmodule : dcc_link_stage
`default_nettype wire

/* dcc_ctrl_pins.sv */
// DDR3 command and control pins: rank power states, command checks and pin drive.
//
// Behaviour
// [RULE1] DRAM clocks and buffers follow clock enable.
// [RULE2] Low clock enable: idle banks precharge, else active.
// [RULE3] Power-down and self-refresh entry are clock synchronous.
// [RULE4] Self-refresh exit needs no clock alignment.
// [RULE5] Clock enable high throughout reads and writes.
// [RULE6] Power-down keeps only clock, termination, enable.
// [RULE7] Self-refresh keeps only the clock enable input.
// [RULE8] DRAM ignores commands with chip select high.
// [RULE9] Four active-low selects, one rank driven low.
// [RULE10] Select and strobes sampled together as command.
// [RULE11] Termination enabled on target rank during writes.
// [RULE12] Own receivers terminated internally for read data.
// [RULE13] DRAM ignores termination when mode disables it.
// [RULE14] DRAM termination covers data, strobe, mask.
// [RULE15] Four active-high termination enables, one per rank.
// [RULE16] Four clock enables, one per rank.
// [RULE17] Row and column strobes, active low, encode commands.
// [RULE18] Write strobe, active low, encodes commands.
// [RULE19] Commands follow the standard DDR3 truth table.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_ctrl_pins
  import dcc_pkg::*;
#(
  parameter int ODT_CYCLES = `DCC_ODT_CYCLES,
  parameter int RX_TERM_CYCLES = `DCC_RX_TERM_CYCLES
)
(
  // Clocks and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic mem_clk,
  // Request port
  input wire logic req_valid,
  input wire logic req_is_pwr,
  input wire dcc_cmd_t req_cmd,
  input wire dcc_pwr_op_t req_pwr_op,
  input wire logic [1:0] req_rank,
  input wire logic [3:0] bank_open,
  input wire logic term_feature_en,
  output logic req_ready,
  output logic req_refused,
  // Status
  output logic rx_term_en,
  output logic [3:0] ranks_power_down,
  output logic [3:0] ranks_self_refresh,
  // Pins
  output logic [3:0] ch0_rank_clock_enables,
  output logic [3:0] ch0_rank_selects_n,
  output logic [3:0] ch0_rank_termination_enables,
  output logic ch0_row_strobe_n,
  output logic ch0_column_strobe_n,
  output logic ch0_write_strobe_n
);
  // ------------------------------------------------------------------
  // Request checks
  // ------------------------------------------------------------------
  dcc_pwr_state_t pwr_state_r [4];
  dcc_pwr_state_t pwr_state_nxt [4];
  logic accept, ok, rx_start;
  logic busy_r, ack_meta_r, ack_sync_r, ack_seen_r, ack_evt, ack_tgl;
  logic req_tgl_r, word_sel_r, word_odt_r;
  dcc_cmd_t word_cmd_r;
  logic [1:0] word_rank_r;
  logic [3:0] word_cke_r, cke_nxt, enc_cs_n;
  logic [2:0] enc_strobes_n, pin_strobes_n;
  logic [7:0] rx_cnt_r;
  dcc_pwr_state_t cur;

  // Both kinds of power-down share this decode.
  function automatic logic in_power_down(input dcc_pwr_state_t st);
    in_power_down = (st == PWR_PD_PRE) || (st == PWR_PD_ACT);
  endfunction : in_power_down

  assign accept = req_valid && req_ready;
  assign cur = pwr_state_r[req_rank];
  assign rx_start = accept && ok && !req_is_pwr && req_cmd == CMD_READ && term_feature_en;

  // A rank that is powered down or in self-refresh takes no command at all,
  // so reads and writes only ever go out with clock enable high.
  always_comb
  begin
    ok = 1'b0;
    if (!req_is_pwr)
      ok = (cur == PWR_ACTIVE); // see [RULE5]
    else
      case (req_pwr_op)
        OP_PD_ENTER: ok = (cur == PWR_ACTIVE);
        OP_PD_EXIT: ok = in_power_down(cur);
        OP_SR_ENTER: ok = (cur == PWR_ACTIVE) && !bank_open[req_rank]; // see [RULE2]
        OP_SR_EXIT: ok = (cur == PWR_SELF_REF);
        default: ok = 1'b0;
      endcase
  end

  // ------------------------------------------------------------------
  // Rank power states
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_rank
    always_comb
    begin
      pwr_state_nxt[i] = pwr_state_r[i];
      if (accept && ok && req_is_pwr && req_rank == 2'(i))
        case (req_pwr_op)
          OP_PD_ENTER: pwr_state_nxt[i] = bank_open[i] ? PWR_PD_ACT : PWR_PD_PRE; // see [RULE2]
          OP_SR_ENTER: pwr_state_nxt[i] = PWR_SELF_REF;
          default: pwr_state_nxt[i] = PWR_ACTIVE;
        endcase
      cke_nxt[i] = (pwr_state_nxt[i] == PWR_ACTIVE); // see [RULE16]
    end

    always_ff @(posedge mclk)
    begin
      if (!nrst)
      begin
        pwr_state_r[i] <= PWR_ACTIVE;
        ranks_power_down[i] <= 1'b0;
        ranks_self_refresh[i] <= 1'b0;
      end
      else
      begin
        pwr_state_r[i] <= pwr_state_nxt[i];
        ranks_power_down[i] <= in_power_down(pwr_state_nxt[i]);
        ranks_self_refresh[i] <= (pwr_state_nxt[i] == PWR_SELF_REF);
      end
    end
  end

  // ------------------------------------------------------------------
  // Word handshake toward the memory clock
  // ------------------------------------------------------------------
  // One word is in flight at a time; the word registers hold still until
  // the acknowledge returns, which keeps the multi-bit crossing safe.
  always_ff @(posedge mclk)
  begin
    ack_meta_r <= ack_tgl;
    ack_sync_r <= ack_meta_r;
  end

  assign ack_evt = ack_sync_r ^ ack_seen_r;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ack_seen_r <= 1'b0;
      busy_r <= 1'b0;
      req_ready <= 1'b0;
      req_refused <= 1'b0;
      req_tgl_r <= 1'b0;
    end
    else
    begin
      ack_seen_r <= ack_sync_r;
      req_refused <= accept && !ok;
      if (accept && ok)
      begin
        busy_r <= 1'b1;
        req_ready <= 1'b0;
        req_tgl_r <= ~req_tgl_r;
      end
      else if (ack_evt)
      begin
        busy_r <= 1'b0;
        req_ready <= 1'b1;
      end
      else
        req_ready <= !busy_r;
    end
  end

  // Self-refresh exit only raises the word's clock enable; no clock edge of
  // the memory is waited on before the request is launched.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      word_sel_r <= 1'b0;
      word_cmd_r <= CMD_NOP;
      word_rank_r <= 2'h0;
      word_cke_r <= 4'h0;
      word_odt_r <= 1'b0;
    end
    else if (accept && ok)
    begin
      word_sel_r <= !req_is_pwr;
      word_cmd_r <= req_cmd;
      word_rank_r <= req_rank;
      word_cke_r <= cke_nxt; // see [RULE4]
      word_odt_r <= term_feature_en;
    end
  end

  dcc_cmd_encode u_encode (
    .sel(word_sel_r),
    .cmd(word_cmd_r),
    .rank(word_rank_r),
    .cs_n(enc_cs_n),
    .strobes_n(enc_strobes_n)
  );

  dcc_link_stage #(.ODT_CYCLES(ODT_CYCLES)) u_link (
    .mem_clk(mem_clk),
    .nrst(nrst),
    .req_tgl(req_tgl_r),
    .w_cs_n(enc_cs_n),
    .w_strobes_n(enc_strobes_n),
    .w_cke(word_cke_r),
    .w_write(word_sel_r && word_cmd_r == CMD_WRITE),
    .w_odt(word_odt_r),
    .w_rank(word_rank_r),
    .ack_tgl(ack_tgl),
    .cke_r(ch0_rank_clock_enables),
    .cs_n_r(ch0_rank_selects_n),
    .odt_r(ch0_rank_termination_enables),
    .strobes_n_r(pin_strobes_n)
  );

  assign ch0_row_strobe_n = pin_strobes_n[2];
  assign ch0_column_strobe_n = pin_strobes_n[1];
  assign ch0_write_strobe_n = pin_strobes_n[0];

  // ------------------------------------------------------------------
  // Receiver termination for read data
  // ------------------------------------------------------------------
  // Read data is terminated inside the controller; the rank's termination
  // pin stays low, and the window closes again to save power.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_cnt_r <= 8'h00;
      rx_term_en <= 1'b0;
    end
    else if (rx_start)
    begin
      rx_cnt_r <= 8'(RX_TERM_CYCLES - 1); // see [RULE12]
      rx_term_en <= 1'b1;
    end
    else if (rx_cnt_r != 8'h00)
    begin
      rx_cnt_r <= rx_cnt_r - 8'h01;
      rx_term_en <= 1'b1;
    end
    else
      rx_term_en <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_rdwr_needs_cke: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE5]
    accept && !req_is_pwr && pwr_state_r[req_rank] != PWR_ACTIVE |=> req_refused && req_ready)
    else $error("command to sleeping rank not refused");
  a_sr_banks_idle: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE2]
    accept && req_is_pwr && req_pwr_op == OP_SR_ENTER && bank_open[req_rank] |=> req_refused)
    else $error("self-refresh entry with open bank");
  a_pd_kind: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE2]
    accept && ok && req_is_pwr && req_pwr_op == OP_PD_ENTER |=>
    pwr_state_r[$past(req_rank)] == ($past(bank_open[req_rank]) ? PWR_PD_ACT : PWR_PD_PRE))
    else $error("wrong power-down kind");
  a_word_stable: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE3]
    busy_r && !ack_evt |=> $stable({word_cke_r, word_cmd_r, word_rank_r, word_sel_r}))
    else $error("word moved during crossing");
  a_sr_exit_cke: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE4]
    accept && ok && req_is_pwr && req_pwr_op == OP_SR_EXIT |=>
    word_cke_r[$past(req_rank)] && req_tgl_r != $past(req_tgl_r))
    else $error("self-refresh exit not launched");
  a_rx_term: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE12]
    rx_start |=> rx_term_en [*8])
    else $error("read termination window short");
  // A refused request must leave the toggle alone; otherwise a stale word
  // would be replayed at the pins.
  a_refuse_quiet: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE5]
    accept && !ok |=> req_tgl_r == $past(req_tgl_r) && !busy_r)
    else $error("refused request launched");
  a_take_closes: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE3]
    accept && ok |=> !req_ready && busy_r)
    else $error("ready not dropped after take");
  a_pwr_deselect: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE9]
    accept && ok && req_is_pwr |=> !word_sel_r && enc_cs_n == `DCC_CS_NONE)
    else $error("power op selected a rank");
  a_one_state: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE2]
    (ranks_power_down & ranks_self_refresh) == 4'h0)
    else $error("rank in two power states");
  a_sr_cke_low: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE2]
    accept && ok && req_is_pwr && req_pwr_op == OP_SR_ENTER |=> !word_cke_r[$past(req_rank)])
    else $error("self-refresh entry kept clock enable");
  // Termination draws power, so it is switched off again as soon as its
  // window is spent.
  a_rx_term_off: assert property (@(posedge mclk) disable iff (!nrst) // see [RULE12]
    rx_cnt_r == 8'h00 && !rx_start |=> !rx_term_en)
    else $error("read termination left on");
  c_pd_precharge: cover property (@(posedge mclk) pwr_state_r[1] == PWR_PD_PRE);
  c_sr_enter: cover property (@(posedge mclk) accept && ok && req_pwr_op == OP_SR_ENTER);
  c_pd_active: cover property (@(posedge mclk) pwr_state_r[0] == PWR_PD_ACT);
  c_refused: cover property (@(posedge mclk) req_refused);
endmodule : dcc_ctrl_pins
`default_nettype wire

/* dcc_dram_model.sv */
// Behavioural group of four DDR3 ranks that watches the command and control pins.
`timescale 1ns/100ps
`default_nettype none
module dcc_dram_model
(
  // Memory clock and bench control
  input wire logic mem_clk,
  input wire logic clr,
  // Pins
  input wire logic [3:0] cke,
  input wire logic [3:0] cs_n,
  input wire logic [3:0] odt,
  input wire logic [2:0] strobes_n,
  // Observations
  output logic [2:0] last_code,
  output logic [3:0] last_sel,
  output logic [7:0] odt_cnt,
  output logic [3:0] odt_mask,
  output logic [7:0] n_viol
);
  // The ranks are taken as having their mode register programmed with
  // termination on; with it off they would ignore the termination pins.
  localparam bit ODT_MODE_ON = 1'b1;

  // ---------------------------------------------------------------------------
  // Pin sampling on the memory clock
  // ---------------------------------------------------------------------------
  // A rank whose clock enable is low has its input buffers off, so any select
  // reaching it is lost; the model counts that as a fault of the controller.
  always @(posedge mem_clk)
  begin
    if (clr)
    begin
      last_code <= 3'h0;
      last_sel <= 4'h0;
      odt_cnt <= 8'h00;
      odt_mask <= 4'h0;
      n_viol <= 8'h00;
    end
    else
    begin
      if (ODT_MODE_ON && odt != 4'h0)
      begin
        odt_cnt <= odt_cnt + 8'h01;
        odt_mask <= odt_mask | odt;
      end
      if (cs_n != 4'hF)
      begin
        last_code <= strobes_n;
        last_sel <= ~cs_n;
        if ($countones(~cs_n) != 1 || (cke & ~cs_n) != ~cs_n)
        begin
          n_viol <= n_viol + 8'h01;
        end
      end
    end
  end
endmodule : dcc_dram_model
`default_nettype wire

/* tb_ddr3_command_control_pins.sv */
// Self-checking bench for the DDR3 command and control pin block.
`timescale 1ns/100ps
`default_nettype none
module tb_ddr3_command_control_pins;
  import dcc_pkg::*;
  logic mclk = 1'b0;
  logic mem_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_is_pwr = 1'b0;
  dcc_cmd_t req_cmd = CMD_NOP;
  dcc_pwr_op_t req_pwr_op = OP_PD_ENTER;
  logic [1:0] req_rank = 2'h0;
  logic [3:0] bank_open = 4'h0;
  logic term_feature_en = 1'b0;
  logic clr = 1'b1;
  logic req_ready, req_refused, rx_term_en;
  logic [3:0] pd, sr, cke, cs_n, odt, m_sel, m_mask;
  logic ras_n, cas_n, we_n;
  logic [2:0] m_code;
  logic [7:0] memory_termination_pins, m_viol;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int rx_cnt = 0;

  always #2 mclk = ~mclk;
  always #40 mem_clk = ~mem_clk;

  dcc_ctrl_pins DUT (.mclk(mclk), .nrst(nrst), .mem_clk(mem_clk), .req_valid(req_valid),
    .req_is_pwr(req_is_pwr), .req_cmd(req_cmd), .req_pwr_op(req_pwr_op), .req_rank(req_rank),
    .bank_open(bank_open), .term_feature_en(term_feature_en), .req_ready(req_ready),
    .req_refused(req_refused), .rx_term_en(rx_term_en), .ranks_power_down(pd),
    .ranks_self_refresh(sr), .ch0_rank_clock_enables(cke), .ch0_rank_selects_n(cs_n),
    .ch0_rank_termination_enables(odt), .ch0_row_strobe_n(ras_n),
    .ch0_column_strobe_n(cas_n), .ch0_write_strobe_n(we_n));

  dcc_dram_model dram (.mem_clk(mem_clk), .clr(clr), .cke(cke), .cs_n(cs_n), .odt(odt),
    .strobes_n({ras_n, cas_n, we_n}), .last_code(m_code), .last_sel(m_sel), .odt_cnt(memory_termination_pins),
    .odt_mask(m_mask), .n_viol(m_viol));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Offers one request, checks the answer and lets the word reach the pins.
  task automatic send(input logic pwr, input dcc_cmd_t c, input dcc_pwr_op_t op,
                      input logic [1:0] r, input logic exp_ref);
    @(posedge mclk);
    #1;
    while (req_ready !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    req_valid = 1'b1;
    req_is_pwr = pwr;
    req_cmd = c;
    req_pwr_op = op;
    req_rank = r;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    check(req_refused, exp_ref);
    check(req_ready, exp_ref);
    while (req_ready !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    repeat (3) @(posedge mem_clk);
    @(posedge mclk);
    #1;
  endtask : send

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  always @(posedge mclk)
  begin
    cyc++;
    if (rx_term_en === 1'b1)
      rx_cnt++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_commands();
    logic [2:0] code [7];
    code = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    for (int i = 0; i < 7; i++)
    begin
      send(1'b0, dcc_cmd_t'(i), OP_PD_ENTER, 2'(i % 4), 1'b0);
      check(m_code, code[i]);
      check(m_sel, 8'h01 << (i % 4));
      check(cke, 4'hF);
    end
    check(m_viol, 8'h00);
    $display("commands done");
  endtask : t_commands

  task automatic t_termination();
    clr = 1'b1;
    @(posedge mem_clk);
    @(posedge mclk);
    #1;
    clr = 1'b0;
    send(1'b0, CMD_WRITE, OP_PD_ENTER, 2'h2, 1'b0);
    check(memory_termination_pins, 8'h00);
    send(1'b0, CMD_READ, OP_PD_ENTER, 2'h1, 1'b0);
    check(m_mask, 4'h0);
    check(8'(rx_cnt), 8'h00);
    term_feature_en = 1'b1;
    send(1'b0, CMD_WRITE, OP_PD_ENTER, 2'h2, 1'b0);
    repeat (4) @(posedge mem_clk);
    @(posedge mclk);
    #1;
    check(memory_termination_pins, 8'h06);
    check(m_mask, 4'h4);
    check(8'(rx_cnt), 8'h00);
    send(1'b0, CMD_READ, OP_PD_ENTER, 2'h1, 1'b0);
    check(8'(rx_cnt), 8'h08);
    check(memory_termination_pins, 8'h06);
    check(m_mask, 4'h4);
    term_feature_en = 1'b0;
    $display("termination done");
  endtask : t_termination

  task automatic t_power();
    bank_open = 4'h1;
    send(1'b1, CMD_NOP, OP_PD_ENTER, 2'h0, 1'b0);
    check(pd, 4'h1);
    check(cke, 4'hE);
    send(1'b0, CMD_READ, OP_PD_ENTER, 2'h0, 1'b1);
    send(1'b1, CMD_NOP, OP_SR_ENTER, 2'h0, 1'b1);
    send(1'b1, CMD_NOP, OP_PD_EXIT, 2'h0, 1'b0);
    check(pd, 4'h0);
    check(cke, 4'hF);
    send(1'b1, CMD_NOP, OP_SR_ENTER, 2'h0, 1'b1);
    bank_open = 4'h0;
    send(1'b1, CMD_NOP, OP_PD_ENTER, 2'h1, 1'b0);
    check(pd, 4'h2);
    check(cke, 4'hD);
    send(1'b0, CMD_WRITE, OP_PD_ENTER, 2'h1, 1'b1);
    send(1'b1, CMD_NOP, OP_PD_EXIT, 2'h1, 1'b0);
    check(pd, 4'h0);
    send(1'b1, CMD_NOP, OP_SR_ENTER, 2'h3, 1'b0);
    check(sr, 4'h8);
    check(cke, 4'h7);
    send(1'b0, CMD_WRITE, OP_PD_ENTER, 2'h3, 1'b1);
    send(1'b1, CMD_NOP, OP_SR_EXIT, 2'h0, 1'b1);
    send(1'b1, CMD_NOP, OP_PD_EXIT, 2'h3, 1'b1);
    send(1'b1, CMD_NOP, OP_SR_EXIT, 2'h3, 1'b0);
    check(sr, 4'h0);
    check(cke, 4'hF);
    send(1'b0, CMD_ACT, OP_PD_ENTER, 2'h3, 1'b0);
    check(m_sel, 4'h8);
    check(m_viol, 8'h00);
    $display("power done");
  endtask : t_power

  initial
  begin
    repeat (12) @(posedge mem_clk);
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    clr = 1'b0;
    t_commands();
    t_termination();
    t_power();
    conclude();
  end
endmodule : tb_ddr3_command_control_pins
`default_nettype wire
